//--- hdl/multiqueue_active_flag_logic.sv
module multiqueue_active_flag_logic #(
  parameter int unsigned NUM_QUEUES  = 128,
  parameter int unsigned QUEUE_DEPTH = 256
) (
  // clock and reset
  input  wire logic                               clk_i,
  input  wire logic                               rst_n_i,
  // write port
  input  wire logic [mq_flag_pkg::QADDR_W-1:0]    write_queue_address_i,
  input  wire logic                               write_address_enable_i,
  input  wire logic                               write_en_i,
  // read port
  input  wire logic [mq_flag_pkg::QADDR_W-1:0]    read_queue_address_i,
  input  wire logic                               read_address_enable_i,
  input  wire logic                               read_en_i,
  // static identity straps and expansion width
  input  wire logic                               device_identity_0_i,
  input  wire logic                               device_identity_1_i,
  input  wire logic                               device_identity_2_i,
  input  wire logic [1:0]                         id_width_i,
  // offset programming port
  input  wire logic                               prog_load_i,
  input  wire logic                               prog_default_i,
  input  wire logic                               prog_default_large_i,
  input  wire logic [mq_flag_pkg::QADDR_W-1:0]    prog_queue_i,
  input  wire logic [$clog2(QUEUE_DEPTH+1)-1:0]   prog_af_offset_i,
  input  wire logic [$clog2(QUEUE_DEPTH+1)-1:0]   prog_ae_offset_i,
  // flags
  output logic                                    empty_flag_n_o,
  output logic                                    empty_flag_oe_n_o,
  output logic                                    almost_full_n_o,
  output logic                                    almost_empty_n_o
);
  localparam int unsigned CW   = $clog2(QUEUE_DEPTH + 1);
  localparam int unsigned LQW  = (NUM_QUEUES > 1) ? $clog2(NUM_QUEUES) : 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(QUEUE_DEPTH);
  // defaults above the queue depth are clipped, never truncated to a wrapped value
  localparam int unsigned DEF_S_I = (mq_flag_pkg::DEF_OFFSET_SMALL > QUEUE_DEPTH) ?
                                    QUEUE_DEPTH : mq_flag_pkg::DEF_OFFSET_SMALL;
  localparam int unsigned DEF_L_I = (mq_flag_pkg::DEF_OFFSET_LARGE > QUEUE_DEPTH) ?
                                    QUEUE_DEPTH : mq_flag_pkg::DEF_OFFSET_LARGE;
  localparam logic [CW-1:0] DEF_S   = CW'(DEF_S_I);
  localparam logic [CW-1:0] DEF_L   = CW'(DEF_L_I);
  localparam int unsigned TP        = mq_flag_pkg::ID_TOP_POS;

  // identity match on the top bits of an address
  wire logic [2:0] id_code = {device_identity_2_i, device_identity_1_i, device_identity_0_i};
  wire logic [2:0] w_top   = write_queue_address_i[TP -: 3];
  wire logic [2:0] r_top   = read_queue_address_i[TP -: 3];
  wire logic       w_match = (id_width_i == mq_flag_pkg::ID_WIDTH_NONE) ? 1'b1 :  // see (R5)
                             (id_width_i == 2'h1) ? (w_top[2] == id_code[0]) :
                             (id_width_i == 2'h2) ? (w_top[2:1] == id_code[1:0]) :
                             (w_top == id_code);
  wire logic       r_match = (id_width_i == mq_flag_pkg::ID_WIDTH_NONE) ? 1'b1 :  // see (R4) see (R5)
                             (id_width_i == 2'h1) ? (r_top[2] == id_code[0]) :
                             (id_width_i == 2'h2) ? (r_top[2:1] == id_code[1:0]) :
                             (r_top == id_code);
  wire logic [LQW-1:0] w_local = write_queue_address_i[LQW-1:0];
  wire logic [LQW-1:0] r_local = read_queue_address_i[LQW-1:0];
  wire logic [LQW-1:0] p_local = prog_queue_i[LQW-1:0];

  // selection pipelines: capture, one more stage, then active queue
  logic [LQW-1:0] wsel1, wsel2, wact;
  logic           wm1, wm2, wact_m;
  logic [LQW-1:0] rsel1, rsel2, ract;
  logic           rm1, rm2, ract_m;

  // three edges from selection to the flag, matching when data may move
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wsel1  <= '0;
      wsel2  <= '0;
      wact   <= '0;
      wm1    <= 1'b0;
      wm2    <= 1'b0;
      wact_m <= 1'b0;
    end else begin
      if (write_address_enable_i) begin
        wsel1 <= w_local;
        wm1   <= w_match;
      end
      wsel2  <= wsel1;  // see (R9)
      wm2    <= wm1;
      wact   <= wsel2;
      wact_m <= wm2;
    end
  end

  // same depth on the read side so the flag lines up with fall-through data
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsel1  <= '0;
      rsel2  <= '0;
      ract   <= '0;
      rm1    <= 1'b0;
      rm2    <= 1'b0;
      ract_m <= 1'b0;
    end else begin
      if (read_address_enable_i) begin
        rsel1 <= r_local;
        rm1   <= r_match;
      end
      rsel2  <= rsel1;  // see (R16)
      rm2    <= rm1;
      ract   <= rsel2;
      ract_m <= rm2;
    end
  end

  // per-queue level, read-side level, offsets and status
  logic [CW-1:0]         count   [NUM_QUEUES];
  logic [CW-1:0]         rcount  [NUM_QUEUES];
  logic [CW-1:0]         af_off  [NUM_QUEUES];
  logic [CW-1:0]         ae_off  [NUM_QUEUES];
  logic [NUM_QUEUES-1:0] wr_late;
  logic [NUM_QUEUES-1:0] af_stat;
  logic [NUM_QUEUES-1:0] ae_stat;

  // moves are refused on a full or empty queue; rcount never exceeds count
  wire logic wr_fire = write_en_i && wact_m && (count[wact] != DEPTH_C);
  wire logic rd_fire = read_en_i && ract_m && (rcount[ract] != '0);
  wire logic [CW-1:0] def_off = prog_default_large_i ? DEF_L : DEF_S;  // see (R7)
  wire logic [CW-1:0] af_clip = (prog_af_offset_i > DEPTH_C) ? DEPTH_C : prog_af_offset_i;
  wire logic [CW-1:0] ae_clip = (prog_ae_offset_i > DEPTH_C) ? DEPTH_C : prog_ae_offset_i;

  genvar q;
  generate
    for (q = 0; q < NUM_QUEUES; q++) begin : g_queue
      wire logic wr_q = wr_fire && (wact == LQW'(q));
      wire logic rd_q = rd_fire && (ract == LQW'(q));
      wire logic ld_q = prog_load_i && (prog_default_i || (p_local == LQW'(q)));
      wire logic [CW-1:0] free_q = DEPTH_C - count[q];

      // offsets held per queue, loaded by default or one queue at a time
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          af_off[q] <= DEF_S;
          ae_off[q] <= DEF_S;
        end else if (ld_q) begin
          af_off[q] <= prog_default_i ? def_off : af_clip;  // see (R8)
          ae_off[q] <= prog_default_i ? def_off : ae_clip;  // see (R15)
        end
      end

      // writes reach the read-side level one cycle late, the extra cycle of a write
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          count[q]   <= '0;
          rcount[q]  <= '0;
          wr_late[q] <= 1'b0;
        end else begin
          count[q]   <= count[q] + CW'(wr_q) - CW'(rd_q);  // see (R13)
          rcount[q]  <= rcount[q] + CW'(wr_late[q]) - CW'(rd_q);  // see (R18) see (R19)
          wr_late[q] <= wr_q;
        end
      end

      // first register stage of each almost flag, kept for every queue
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          af_stat[q] <= 1'b0;
          ae_stat[q] <= 1'b1;
        end else begin
          af_stat[q] <= (free_q <= af_off[q]);  // see (R6) see (R21)
          ae_stat[q] <= (rcount[q] <= ae_off[q]);  // see (R14) see (R21)
        end
      end
    end
  endgenerate

  // the read that takes the last word raises the ready flag on its own edge
  wire logic [CW-1:0] r_level   = rcount[ract] - CW'(rd_fire);
  wire logic          next_ef_n = (r_level == '0);  // see (R20)

  // second register stage; single clock means the skew case cannot arise
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      almost_full_n_o   <= 1'b1;
      almost_empty_n_o  <= 1'b1;
      empty_flag_n_o    <= 1'b1;
      empty_flag_oe_n_o <= 1'b1;
    end else begin
      almost_full_n_o   <= ~af_stat[wact];  // see (R10) see (R11) see (R12)
      almost_empty_n_o  <= ~ae_stat[ract];  // see (R17) see (R19)
      empty_flag_n_o    <= next_ef_n;       // see (R3)
      empty_flag_oe_n_o <= ~ract_m;         // see (R1) see (R2)
    end
  end
endmodule

//--- hdl/mq_flag_pkg.sv
// Operation
// (R1) controller reads queues of only one expanded device at a time
// (R2) empty flag floats by itself when no local queue is read-selected
// (R3) flag stays driven and follows each newly selected local read queue
// (R4) drive empty flag only when top identity bits of read address match
// (R5) identity width 1, 2 or 3 bits for 2, 4 or 8 devices, 256 queues
// (R6) almost-full kept for all queues, write-selected queue shown on output
// (R7) default programming loads offset 8 or 128, else loaded by program port
// (R8) each queue has its own almost-full offset from 0 to its depth
// (R9) almost-full shows new write queue on third edge after selection
// (R10) almost-full double registered: two cycles after write or read
// (R11) skew violation may add one flag cycle; one clock here, never occurs
// (R12) almost-full changes only on rising clock edges
// (R13) non-active queues keep updating their almost-full status, also on reads
// (R14) almost-empty kept for all queues, read-selected queue shown on output
// (R15) each queue own almost-empty offset 0 to depth, default 8 or 128
// (R16) almost-empty shows new read queue on third edge after selection
// (R17) almost-empty asserts low two cycles after crossing read
// (R18) write clearing almost-empty deasserts it after three cycles
// (R19) almost-empty changes on rising edges; idle queues update on writes
// (R20) after last word read, ready/empty flag goes high at that read edge
// (R21) assert at or below offset: free space for full, words for empty
package mq_flag_pkg;
  localparam int unsigned QADDR_W          = 8;    // queue address bus width
  localparam int unsigned ID_W             = 3;    // widest identity code
  localparam int unsigned MAX_QUEUES_TOTAL = 256;  // across all expanded devices
  localparam int unsigned DEF_OFFSET_SMALL = 8;
  localparam int unsigned DEF_OFFSET_LARGE = 128;
  localparam int unsigned ID_TOP_POS       = 7;    // identity bits sit from here down
  localparam logic [1:0]  ID_WIDTH_NONE    = 2'h0; // single device, always drives
endpackage

//--- tb/ef_bus_model.sv
module ef_bus_model (
  // clock
  input  wire logic clk_i,
  // device side of the shared empty line
  input  wire logic flag_i,
  input  wire logic oe_n_i,
  // what the controller sees
  output logic      level_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last = 1'b0;
  // no pull on the line: a released line toggles rather than keeping a stale level
  always @(posedge clk_i) begin
    last <= oe_n_i ? ~last : flag_i;
  end
  assign level_o = oe_n_i ? last : flag_i;  // single reader device at a time
endmodule

//--- tb/mq_flag_sva.sv
module mq_flag_sva (
  // clock, reset and strobes
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic write_en_i,
  input wire logic write_address_enable_i,
  input wire logic read_en_i,
  input wire logic read_address_enable_i,
  input wire logic prog_load_i,
  // flags
  input wire logic empty_flag_n_o,
  input wire logic empty_flag_oe_n_o,
  input wire logic almost_full_n_o,
  input wire logic almost_empty_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // quiet windows cover a selection flowing three edges plus one sampling edge
  sequence s_rd_idle;
    !read_address_enable_i [*5];
  endsequence
  sequence s_wr_idle;
    !(write_en_i || read_en_i || write_address_enable_i || prog_load_i) [*5];
  endsequence
  // an output updated at edge k is first sampled at edge k+1, hence one more past cycle
  AST_OE_QUIET: assert property (s_rd_idle |-> $stable(empty_flag_oe_n_o))
    else $error("empty drive moved without read select");
  AST_AF_QUIET: assert property (s_wr_idle |-> $stable(almost_full_n_o))
    else $error("almost full moved without cause");
  AST_AF_FALL: assert property ($fell(almost_full_n_o) |->
    $past(write_en_i, 3) || $past(write_address_enable_i, 4) || $past(prog_load_i, 3))
    else $error("almost full asserted at wrong time");
  AST_AF_RISE: assert property ($rose(almost_full_n_o) |->
    $past(read_en_i, 3) || $past(write_address_enable_i, 4) || $past(prog_load_i, 3))
    else $error("almost full released at wrong time");
  AST_AE_FALL: assert property ($fell(almost_empty_n_o) |-> !$past(rst_n_i, 2) ||
    $past(read_en_i, 3) || $past(read_address_enable_i, 4) || $past(prog_load_i, 3))
    else $error("almost empty asserted at wrong time");
  AST_AE_RISE: assert property ($rose(almost_empty_n_o) |->
    $past(write_en_i, 4) || $past(read_address_enable_i, 4) || $past(prog_load_i, 3))
    else $error("almost empty released at wrong time");
  AST_EF_RISE: assert property ($rose(empty_flag_n_o) |-> $past(read_en_i) || $past(read_address_enable_i, 4))
    else $error("empty rose at wrong time");
  AST_EF_FALL: assert property ($fell(empty_flag_n_o) |-> $past(write_en_i, 3) || $past(read_address_enable_i, 4))
    else $error("empty fell at wrong time");
endmodule
bind multiqueue_active_flag_logic mq_flag_sva sva_u (.*);

//--- tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DEP = 16;
  logic       clk_i = 0, rst_n_i = 0, wae = 0, we = 0, rae = 0, re = 0, pl = 0, pd = 0, pdl = 0;
  logic [7:0] wa = 8'h00, ra = 8'h00, pq = 8'h00;
  logic [4:0] afo = 5'h00, aeo = 5'h00;
  logic       ef, oe_n, af, ae, bus;
  int         errors = 0, cmp_count = 0, cyc = 0;
  always #25 clk_i = ~clk_i;
  // identity 5 on three bits, small queues keep the run short
  multiqueue_active_flag_logic #(.NUM_QUEUES(4), .QUEUE_DEPTH(DEP)) dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .write_queue_address_i(wa), .write_address_enable_i(wae), .write_en_i(we),
    .read_queue_address_i(ra), .read_address_enable_i(rae), .read_en_i(re), .device_identity_0_i(1'b1),
    .device_identity_1_i(1'b0), .device_identity_2_i(1'b1), .id_width_i(2'h3), .prog_load_i(pl),
    .prog_default_i(pd), .prog_default_large_i(pdl), .prog_queue_i(pq), .prog_af_offset_i(afo),
    .prog_ae_offset_i(aeo), .empty_flag_n_o(ef), .empty_flag_oe_n_o(oe_n), .almost_full_n_o(af),
    .almost_empty_n_o(ae));
  ef_bus_model bus_u (.clk_i(clk_i), .flag_i(ef), .oe_n_i(oe_n), .level_o(bus));
  task automatic chk(input string what, input logic seen, input logic exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %b seen %b", what, exp, seen);
    end
  endtask
  // inputs always move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic sel(input logic [7:0] a);
    wa = a;
    ra = a;
    wae = 1;
    rae = 1;
    tick(1);
    wae = 0;
    rae = 0;
    tick(2);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // almost full when free space is at or below the offset
  function automatic logic af_x(input int lvl, input int off);
    return !((DEP - lvl) <= off);
  endfunction
  // hang guard, the run needs well under this
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      tally_and_finish();
    end
  end
  initial begin
    int n;
    int ao;
    int eo;
    void'($urandom(10513));
    repeat (10) @(posedge clk_i);
    #1 rst_n_i = 1;
    sel(8'h41);
    tick(1);
    chk("oe_n", oe_n, 1'b1);
    for (int i = 0; i < 4; i++) begin
      pd = (i < 2);
      pdl = (i == 1);
      pq = 8'(i);
      afo = 5'($urandom_range(0, 16));
      aeo = 5'($urandom_range(0, 16));
      pl = 1;
      tick(1);
      pl = 0;
      // large default of 128 is clipped to the queue depth
      ao = (i == 0) ? 8 : (i == 1) ? DEP : int'(afo);
      eo = (i == 0) ? 8 : (i == 1) ? DEP : int'(aeo);
      sel({3'h5, 3'h0, 2'(i)});
      tick(1);
      chk("oe_n", oe_n, 1'b0);
      chk("bus", bus, 1'b1);
      n = (i == 3) ? DEP : $urandom_range(1, 15);
      we = 1;
      tick(n);
      we = 0;
      tick(4);
      chk("af", af, af_x(n, ao));
      chk("ae", ae, !(n <= eo));
      chk("ef", ef, 1'b0);
      re = 1;
      tick(n - 1);
      chk("ef", ef, 1'b0);
      tick(1);
      re = 0;
      chk("ef", ef, 1'b1);
      tick(3);
      chk("af", af, af_x(0, ao));
      chk("ae", ae, 1'b0);
      $display("test %0d done with %0d words", i, n);
    end
    tally_and_finish();
  end
endmodule
